/* File: src/vars_core.sv */
// Execution datapath for the SIMD arithmetic right shifts, one cycle deep.
// Assumes the pipeline presents a decoded-slot request with operand values
// already read; a result or exception shows one edge after the request.
`default_nettype none

module vars_core (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire vars_pkg::vars_req_s i_req,
  output vars_pkg::vars_resp_s o_resp
);
  import vars_pkg::*;

  // ----------------------------------------------------------------------
  // Lane arithmetic
  // ----------------------------------------------------------------------
  // One shifter serves every lane width: the lane arrives sign-extended to
  // 32 bits, and a guard bit below it becomes the top discarded bit.
  function automatic logic [31:0] asr_lane(input logic [31:0] a,
                                           input logic [4:0] s,
                                           input logic rnd);
    logic [32:0] t;
    t = 33'($signed({a, 1'b0}) >>> s);
    if (rnd) begin
      t = t + 33'h1;
    end
    return t[32:1];
  endfunction

  function automatic logic [63:0] lanes8(input logic [63:0] a,
                                         input logic [4:0] s,
                                         input logic rnd);
    logic [31:0] t;
    lanes8 = '0;
    for (int i = 0; i < 8; i++) begin
      t = asr_lane({{24{a[8*i+7]}}, a[8*i +: 8]}, s, rnd);
      lanes8[8*i +: 8] = t[7:0];
    end
  endfunction

  function automatic logic [63:0] lanes16(input logic [63:0] a,
                                          input logic [4:0] s,
                                          input logic rnd);
    logic [31:0] t;
    lanes16 = '0;
    for (int i = 0; i < 4; i++) begin
      t = asr_lane({{16{a[16*i+15]}}, a[16*i +: 16]}, s, rnd);
      lanes16[16*i +: 16] = t[15:0];
    end
  endfunction

  function automatic logic [63:0] lanes32(input logic [63:0] a,
                                          input logic [4:0] s,
                                          input logic rnd);
    logic [31:0] t;
    lanes32 = '0;
    for (int i = 0; i < 2; i++) begin
      t = asr_lane(a[32*i +: 32], s, rnd);
      lanes32[32*i +: 32] = t;
    end
  endfunction

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  function automatic vars_op_e decode(input logic [31:0] ins);
    logic [5:0] maj;
    logic [5:0] fn;
    logic [4:0] sub;
    maj = ins[MAJOR_LSB +: 6];
    fn = ins[FUNC_LSB +: 6];
    sub = ins[SUB_LSB +: 5];
    decode = OP_NONE;
    if (maj == EXTENSION_MAJOR_OPCODE &&
        fn == NARROW_VECTOR_SHIFT_FUNCTION) begin
      case (sub)
        SUB_FOUR_BYTES: decode = OP_FOUR_BYTES;
        SUB_ROUND_FOUR_BYTES: decode = OP_ROUND_FOUR_BYTES;
        SUB_ROUND_SINGLE_WORD: decode = OP_ROUND_SINGLE_WORD;
        default: decode = OP_NONE;
      endcase
    end else if (maj == EXTENSION_MAJOR_OPCODE &&
                 fn == WIDE_VECTOR_SHIFT_FUNCTION) begin
      case (sub)
        SUB_QUAD_HALVES: decode = OP_QUAD_HALVES;
        SUB_ROUND_QUAD_HALVES: decode = OP_ROUND_QUAD_HALVES;
        SUB_PAIR_WORDS: decode = OP_PAIR_WORDS;
        SUB_ROUND_PAIR_WORDS: decode = OP_ROUND_PAIR_WORDS;
        SUB_VAR_EIGHT_BYTES: decode = OP_VAR_EIGHT_BYTES;
        SUB_VAR_ROUND_EIGHT_BYTES: decode = OP_VAR_ROUND_EIGHT_BYTES;
        default: decode = OP_NONE;
      endcase
    end
  endfunction

  vars_op_e op;
  logic bad_form;
  logic [63:0] src;
  logic [4:0] shift_count;
  logic [4:0] var_count;
  logic [63:0] res;
  logic [63:0] bytes4;
  logic [63:0] word1;

  assign op = decode(i_req.instr);
  assign src = i_req.src;
  assign shift_count = i_req.instr[CNT_LSB +: 5];
  // Upper bits of the count register are ignored by design
  assign var_count = {2'b00, i_req.cnt[VAR_CNT_W-1:0]};

  // Must-be-zero bits under the count field make the word reserved
  always_comb begin
    bad_form = 1'b0;
    case (op)
      OP_FOUR_BYTES, OP_ROUND_FOUR_BYTES: begin
        bad_form = |i_req.instr[QB_ZERO_LSB +: 2];
      end
      OP_QUAD_HALVES, OP_ROUND_QUAD_HALVES: begin
        bad_form = i_req.instr[QH_ZERO_BIT];
      end
      default: bad_form = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------------
  // Result select
  // ----------------------------------------------------------------------
  always_comb begin
    bytes4 = lanes8(src, {2'b00, shift_count[2:0]},
                    op == OP_ROUND_FOUR_BYTES);
    word1 = lanes32(src, shift_count, 1'b1);
    case (op)
      OP_FOUR_BYTES, OP_ROUND_FOUR_BYTES: begin
        res = {{32{bytes4[31]}}, bytes4[31:0]};
      end
      OP_QUAD_HALVES, OP_ROUND_QUAD_HALVES: begin
        res = lanes16(src, {1'b0, shift_count[3:0]},
                      op == OP_ROUND_QUAD_HALVES);
      end
      OP_PAIR_WORDS, OP_ROUND_PAIR_WORDS: begin
        res = lanes32(src, shift_count, op == OP_ROUND_PAIR_WORDS);
      end
      OP_ROUND_SINGLE_WORD: begin
        res = {{32{word1[31]}}, word1[31:0]};
      end
      OP_VAR_EIGHT_BYTES, OP_VAR_ROUND_EIGHT_BYTES: begin
        res = lanes8(src, var_count,
                     op == OP_VAR_ROUND_EIGHT_BYTES);
      end
      default: res = '0;
    endcase
  end

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  vars_resp_s st_q;
  vars_resp_s st_d;

  // Exceptions never look at operand values, only at the encoding and
  // the enable, so a shift can never trap on its data.
  always_comb begin
    st_d = st_q;
    st_d.valid = 1'b0;
    st_d.rsvd_exc = 1'b0;
    st_d.dis_exc = 1'b0;
    if (i_req.valid && op != OP_NONE) begin
      if (bad_form) begin
        st_d.rsvd_exc = 1'b1;
      end else if (!i_req.ext_en) begin
        st_d.dis_exc = 1'b1;
      end else begin
        st_d.valid = 1'b1;
        st_d.result = res;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      st_q <= RST_RESP;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_resp = st_q;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  logic [16:0] chk_t17;
  logic [32:0] chk_t33;
  logic [15:0] exp_qh_top;
  logic [63:0] exp_pw;
  logic [7:0] exp_obv_top;
  logic [7:0] exp_qb_low;

  assign chk_t17 = 17'($signed({src[15:0], 1'b0}) >>> shift_count[3:0]) +
                   17'h1;
  assign chk_t33 = 33'($signed({src[31:0], 1'b0}) >>> shift_count) + 33'h1;
  assign exp_qh_top = 16'($signed(src[63:48]) >>> shift_count[3:0]);
  assign exp_pw = {32'($signed(src[63:32]) >>> shift_count),
                   32'($signed(src[31:0]) >>> shift_count)};
  assign exp_obv_top = 8'($signed(src[63:56]) >>> i_req.cnt[2:0]);
  assign exp_qb_low = 8'($signed(src[7:0]) >>> shift_count[2:0]);

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  chk_qb_zero_pass: assert property (
    o_resp.valid && $past(op) == OP_ROUND_FOUR_BYTES &&
    $past(shift_count[2:0]) == 3'h0 |->
    o_resp.result[31:0] == $past(src[31:0]))
    else $error("rounding byte shift by zero altered a lane");

  chk_qb_upper_fill: assert property (
    o_resp.valid && ($past(op) == OP_FOUR_BYTES ||
    $past(op) == OP_ROUND_FOUR_BYTES) |->
    o_resp.result[63:32] == {32{o_resp.result[31]}} &&
    ($past(op) != OP_FOUR_BYTES ||
     o_resp.result[7:0] == $past(exp_qb_low)))
    else $error("byte shift result or upper fill wrong");

  chk_qh_top_lane: assert property (
    o_resp.valid && $past(op) == OP_QUAD_HALVES |->
    o_resp.result[63:48] == $past(exp_qh_top))
    else $error("quad halfword top lane wrong");

  chk_qh_round_lane: assert property (
    o_resp.valid && $past(op) == OP_ROUND_QUAD_HALVES |->
    o_resp.result[15:0] == $past(chk_t17[16:1]))
    else $error("rounded halfword lane wrong");

  chk_pw_lanes: assert property (
    o_resp.valid && $past(op) == OP_PAIR_WORDS |->
    o_resp.result == $past(exp_pw))
    else $error("pair word result wrong");

  chk_word_round_sext: assert property (
    o_resp.valid && $past(op) == OP_ROUND_SINGLE_WORD |->
    o_resp.result == {{32{$past(chk_t33[32])}}, $past(chk_t33[32:1])})
    else $error("rounded single word wrong");

  chk_var_count: assert property (
    o_resp.valid && $past(op) == OP_VAR_EIGHT_BYTES |->
    o_resp.result[63:56] == $past(exp_obv_top))
    else $error("variable byte shift used wrong count");

  chk_exc_cause: assert property (
    o_resp.rsvd_exc || o_resp.dis_exc |->
    $past(i_req.valid) && $past(op) != OP_NONE && !o_resp.valid &&
    (o_resp.rsvd_exc ? $past(bad_form) :
     !$past(bad_form) && !$past(i_req.ext_en)))
    else $error("exception without its encoding cause");

  chk_valid_one_cycle: assert property (
    i_req.valid && op != OP_NONE && !bad_form && i_req.ext_en |=>
    o_resp.valid ##1 (!o_resp.valid ||
    $past(i_req.valid && op != OP_NONE && !bad_form && i_req.ext_en)))
    else $error("result not presented one cycle after request");

endmodule

`default_nettype wire

/* File: pkg/vars_pkg.sv */
// Shared constants and carriers for the vector arithmetic right shifter.
// Assumes a 32-bit instruction word and 64-bit general registers.
`default_nettype none

package vars_pkg;

  // ----------------------------------------------------------------------
  // Instruction fields
  // ----------------------------------------------------------------------
  localparam int unsigned MAJOR_LSB = 26;
  localparam int unsigned CNT_LSB = 21;
  localparam int unsigned SUB_LSB = 6;
  localparam int unsigned FUNC_LSB = 0;
  localparam int unsigned QB_ZERO_LSB = 24;
  localparam int unsigned QH_ZERO_BIT = 25;
  localparam int unsigned VAR_CNT_W = 3;

  localparam logic [5:0] EXTENSION_MAJOR_OPCODE = 6'h1F;
  localparam logic [5:0] WIDE_VECTOR_SHIFT_FUNCTION = 6'h17;
  localparam logic [5:0] NARROW_VECTOR_SHIFT_FUNCTION = 6'h13;

  localparam logic [4:0] SUB_FOUR_BYTES = 5'h04;
  localparam logic [4:0] SUB_ROUND_FOUR_BYTES = 5'h05;
  localparam logic [4:0] SUB_QUAD_HALVES = 5'h09;
  localparam logic [4:0] SUB_ROUND_QUAD_HALVES = 5'h0D;
  localparam logic [4:0] SUB_PAIR_WORDS = 5'h11;
  localparam logic [4:0] SUB_ROUND_PAIR_WORDS = 5'h15;
  localparam logic [4:0] SUB_ROUND_SINGLE_WORD = 5'h15;
  localparam logic [4:0] SUB_VAR_EIGHT_BYTES = 5'h06;
  localparam logic [4:0] SUB_VAR_ROUND_EIGHT_BYTES = 5'h07;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NONE,
    OP_FOUR_BYTES,
    OP_ROUND_FOUR_BYTES,
    OP_QUAD_HALVES,
    OP_ROUND_QUAD_HALVES,
    OP_PAIR_WORDS,
    OP_ROUND_PAIR_WORDS,
    OP_ROUND_SINGLE_WORD,
    OP_VAR_EIGHT_BYTES,
    OP_VAR_ROUND_EIGHT_BYTES
  } vars_op_e;

  typedef struct packed {
    logic valid;
    logic [31:0] instr;
    logic [63:0] src;
    logic [63:0] cnt;
    logic ext_en;
  } vars_req_s;

  typedef struct packed {
    logic valid;
    logic [63:0] result;
    logic rsvd_exc;
    logic dis_exc;
  } vars_resp_s;

  localparam vars_resp_s RST_RESP = '0;

endpackage

`default_nettype wire

/* File: verification/vars_pipe_model.sv */
// Pipeline model: hands decoded-slot requests to the shifter.
// Assumes the bench calls its tasks; drives on the falling edge.
`default_nettype none
module vars_pipe_model (
  input wire logic i_ref_clk,
  output var vars_pkg::vars_req_s o_req
);
  timeunit 1ns;
  timeprecision 1ps;
  import vars_pkg::*;

  initial o_req = '0;

  task automatic send(input logic [31:0] ins, input logic [63:0] src,
    input logic [63:0] cnt, input logic en);
    @(negedge i_ref_clk);
    o_req <= '{1'b1, ins, src, cnt, en};
  endtask

  // Released operands toggle so a stale value is never mistaken for data
  task automatic idle(input int n);
    repeat (n) begin
      @(negedge i_ref_clk);
      o_req.valid <= 1'b0;
      o_req.instr <= ~o_req.instr;
      o_req.src <= ~o_req.src;
      o_req.cnt <= ~o_req.cnt;
    end
  endtask
endmodule
`default_nettype wire

/* File: verification/vars_core_tb.sv */
// Self-checking bench for the arithmetic right shifter.
// Assumes one clock; expectations queued at issue, popped on response.
`default_nettype none
module vars_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import vars_pkg::*;
  localparam logic [5:0] W6 = WIDE_VECTOR_SHIFT_FUNCTION;
  localparam logic [5:0] N6 = NARROW_VECTOR_SHIFT_FUNCTION;
  localparam logic [5:0] FN [9] = '{N6, N6, W6, W6, W6, W6, N6, W6, W6};
  localparam logic [4:0] SB [9] = '{SUB_FOUR_BYTES, SUB_ROUND_FOUR_BYTES,
    SUB_QUAD_HALVES, SUB_ROUND_QUAD_HALVES, SUB_PAIR_WORDS,
    SUB_ROUND_PAIR_WORDS, SUB_ROUND_SINGLE_WORD, SUB_VAR_EIGHT_BYTES,
    SUB_VAR_ROUND_EIGHT_BYTES};
  localparam int LW [9] = '{8, 8, 16, 16, 32, 32, 32, 8, 8};
  localparam int CB [9] = '{3, 3, 4, 4, 5, 5, 5, 3, 3};
  localparam bit RN [9] = '{0, 1, 0, 1, 0, 1, 1, 0, 1};
  // Mixed lane extremes: most negative, most positive, carries on round
  localparam logic [63:0] EDGE = 64'h807F_8001_7FFF_FF80;

  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  vars_req_s req;
  vars_resp_s resp;
  vars_resp_s exp_q [$];
  logic [63:0] last_res = '0;
  int num_errors = 0;
  int samples_checked = 0;
  int cycles = 0;

  initial begin
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  vars_pipe_model u_pipe (.i_ref_clk(i_ref_clk), .o_req(req));
  vars_core u_dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_req(req), .o_resp(resp));

  function automatic logic [63:0] lane_shift(logic [63:0] a, int w, int s,
    bit r);
    longint v;
    v = longint'(a << (64 - w)) >>> (64 - w);
    if (r && s != 0) begin
      v = ((v >>> (s - 1)) + 1) >>> 1;
    end else begin
      v = v >>> s;
    end
    return 64'(v);
  endfunction

  function automatic logic [63:0] expect_res(int op, logic [63:0] src,
    int s);
    logic [63:0] r;
    int w;
    int n;
    r = '0;
    w = LW[op];
    n = (op < 2) ? 4 : (op == 6) ? 1 : 64 / w;
    for (int i = 0; i < n; i++) begin
      r = r | ((lane_shift(src >> (i * w), w, s, RN[op]) &
        ((64'h1 << w) - 64'h1)) << (i * w));
    end
    if (op < 2 || op == 6) begin
      r[63:32] = {32{r[31]}};
    end
    return r;
  endfunction

  task automatic check(input vars_resp_s seen, input vars_resp_s want);
    samples_checked++;
    if (seen !== want) begin
      num_errors++;
      $display("FAIL %0t: resp %h expected %h", $time, seen, want);
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic issue(input int op, input int s, input logic [63:0] src,
    input logic en, input logic [1:0] bad);
    logic [31:0] ins;
    logic [63:0] cnt;
    vars_resp_s e;
    ins = $urandom;
    cnt = {$urandom, $urandom};
    ins[31:26] = EXTENSION_MAJOR_OPCODE;
    ins[10:6] = SB[op];
    ins[5:0] = FN[op];
    if (op > 6) begin
      cnt[2:0] = 3'(s);
    end else begin
      ins[25:21] = 5'(s);
    end
    if (op < 2) begin
      ins[25:24] = bad;
    end else if (op < 4 && bad != 2'b00) begin
      ins[25] = 1'b1;
    end
    e = '0;
    e.result = last_res;
    if (bad != 2'b00) begin
      e.rsvd_exc = 1'b1;
    end else if (!en) begin
      e.dis_exc = 1'b1;
    end else begin
      e.valid = 1'b1;
      e.result = expect_res(op, src, s);
      last_res = e.result;
    end
    exp_q.push_back(e);
    u_pipe.send(ins, src, cnt, en);
  endtask

  task automatic drain(input string name);
    u_pipe.idle(1);
    for (int i = 0; i < 8 && exp_q.size() != 0; i++) begin
      @(negedge i_ref_clk);
    end
    if (exp_q.size() != 0) begin
      num_errors++;
      $display("FAIL %0t: response missing", $time);
    end
    $display("test %s done", name);
  endtask

  always @(negedge i_ref_clk) begin
    if ((resp.valid | resp.rsvd_exc | resp.dis_exc) !== 1'b0) begin
      if (exp_q.size() == 0) begin
        num_errors++;
        $display("FAIL %0t: unexpected response", $time);
      end else begin
        check(resp, exp_q.pop_front());
      end
    end
  end

  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      $display("FAIL %0t: timeout", $time);
      test_done();
    end
  end

  initial begin
    void'($urandom(32'h65DDFC34));
    repeat (6) @(negedge i_ref_clk);
    check(resp, RST_RESP);
    i_rst_n = 1'b1;
    $display("test reset done");
    for (int op = 0; op < 9; op++) begin
      for (int s = 0; s < (1 << CB[op]); s++) begin
        issue(op, s, {$urandom, $urandom}, 1'b1, 2'b00);
        issue(op, s, EDGE, 1'b1, 2'b00);
      end
    end
    drain("sweep");
    issue(0, 3, EDGE, 1'b1, 2'b01);
    issue(1, 2, EDGE, 1'b0, 2'b10);
    issue(3, 5, EDGE, 1'b1, 2'b01);
    for (int op = 0; op < 9; op++) begin
      issue(op, 1, {$urandom, $urandom}, 1'b0, 2'b00);
    end
    issue(5, 31, EDGE, 1'b1, 2'b00);
    drain("refusal");
    u_pipe.send({6'h1E, 15'h0000, SUB_QUAD_HALVES, W6}, EDGE, '0, 1'b1);
    u_pipe.send({EXTENSION_MAJOR_OPCODE, 15'h0000, SUB_FOUR_BYTES, W6},
      EDGE, '0, 1'b1);
    issue(2, 15, EDGE, 1'b1, 2'b00);
    drain("ignored");
    issue(4, 7, EDGE, 1'b1, 2'b00);
    u_pipe.idle(1);
    i_rst_n = 1'b0;
    repeat (2) @(negedge i_ref_clk);
    check(resp, RST_RESP);
    last_res = '0;
    i_rst_n = 1'b1;
    issue(7, 0, EDGE, 1'b1, 2'b00);
    issue(8, 7, EDGE, 1'b1, 2'b00);
    drain("midreset");
    test_done();
  end
endmodule
`default_nettype wire
